/* File: pkg/iltc_pkg.sv */
// Constants, field positions and carrier types for the level-1 translation
// cache control block.
// Assumes one core clock domain and a plain register port in front of it.
package iltc_pkg;
    // ==========================================================
    // Register indices (the port address is the index itself)
    localparam logic [7:0] OFF_DBG_A = 8'h06;
    localparam logic [7:0] OFF_DBG_B = 8'h07;
    localparam logic [7:0] OFF_DBG_STAT = 8'h08;
    localparam logic [7:0] OFF_CTRL0 = 8'h0C;
    localparam logic [7:0] OFF_CTRL1 = 8'h0D;
    localparam logic [7:0] OFF_CTRL2 = 8'h0E;
    localparam logic [7:0] OFF_CTRL3 = 8'h0F;
    localparam logic [7:0] OFF_BANK_SEL = 8'h10;
    localparam logic [7:0] OFF_BANK_DIS = 8'h11;
    localparam logic [7:0] OFF_WQ_A = 8'h20;
    localparam logic [7:0] OFF_WQ_B = 8'h21;
    localparam logic [7:0] OFF_WQ_C = 8'h22;
    localparam logic [7:0] OFF_WQ_D = 8'h23;
    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_DBG = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL0 = 32'h0000_040C;
    localparam logic [31:0] RST_CTRL1 = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL2 = 32'h000F_F0C0;
    localparam logic [31:0] RST_CTRL3 = 32'h0005_1615;
    localparam logic [31:0] RST_BANK = 32'h0000_0000;
    // ==========================================================
    // Writable bits per register; everything else reads back as built
    localparam logic [31:0] WM_CTRL0 = 32'h0000_3F2F;
    localparam logic [31:0] WM_CTRL1 = 32'h7FFF_DF77;
    localparam logic [31:0] WM_CTRL2 = 32'h0FFF_FFF0;
    localparam logic [31:0] WM_BANK_SEL = 32'h0000_FFFF;
    localparam logic [31:0] WM_BANK_DIS = 32'h0000_3F3F;
    // ==========================================================
    // Field positions
    localparam int B_SMALL_IRQ = 0;
    localparam int B_PHANTOM_KEEP = 0;
    localparam int B_CW_NO_WQ = 2;
    localparam int B_CW_NO_RD = 3;
    localparam int B_INV_NO_WQ = 4;
    localparam int B_INV_NO_RD = 5;
    localparam int B_OUTST_FILT = 11;
    localparam int B_UNFILT_OFF = 0;
    localparam int B_FRAG_OFF = 1;
    localparam int B_CACHE_RO = 2;
    localparam int B_CACHE_WO = 3;
    localparam int P_CREDIT = 8;
    localparam int P_CACHE_CNT = 20;
    localparam int P_ENTRIES = 24;
    localparam int P_VQ_CNT = 28;
    localparam int P_PORT_BITS = 0;
    localparam int B_BYPASS = 9;
    localparam int B_PARITY_MISS = 10;
    localparam int B_DTE_OFF = 12;
    localparam int P_ENTRY_DIS = 14;
    localparam int B_ATS_NOBUF = 19;
    localparam int B_SND_FILT_OFF = 20;
    localparam int B_ORDER = 21;
    localparam int B_INV_ALL = 22;
    localparam int B_REQID_HASH = 26;
    localparam int B_INTERLEAVE = 27;
    localparam int B_NO_VA_FILT = 28;
    localparam int B_COARSE = 29;
    localparam int P_WM_FILL = 4;
    localparam int P_CACHE1_DIS = 8;
    localparam int P_INV_STATE = 8;
    // ==========================================================
    // Completion sequencer states, one-hot
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_cmd = 3'h2,
        st_inv = 3'h4
    } iltc_state_type;
    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } iltc_bus_type;
    // Lookup presented by the cache datapath
    typedef struct packed {
        logic valid;
        logic [2:0] func;
        logic phantom;
        logic [7:0] port_id;
        logic [7:0] va;
        logic hit;
        logic parity_fail;
    } iltc_lookup_type;
    // Lookup result after control steering
    typedef struct packed {
        logic valid;
        logic [2:0] func;
        logic [3:0] vq;
        logic bank;
        logic hit;
        logic bypass;
    } iltc_result_type;
endpackage

/* File: src/iltc_ctrl.sv */
// Level-1 translation cache control: indirect register file, request
// steering, completion sequencer and workqueue status readback.
// Assumes all inputs come from logic on clk; the register port never waits.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module iltc_ctrl #(
    parameter logic [1:0] CACHE_COUNT = 2'h1,     // Caches built
    parameter logic [3:0] ENTRIES_EXP = 4'h0,     // Log2 entries per cache
    parameter logic [2:0] VQ_CODE = 3'h0          // Virtual queue count code
) (
    input wire logic clk,
    input wire logic srst,
    input wire iltc_pkg::iltc_bus_type bus,
    output logic [31:0] rdata,
    input wire logic small_irq_evt,
    input wire logic cmd_wait_req,
    input wire logic inval_req,
    input wire logic wq_empty,
    input wire logic reads_done,
    output logic cmd_wait_done,
    output logic inval_done,
    input wire iltc_pkg::iltc_lookup_type lookup,
    output iltc_pkg::iltc_result_type result,
    input wire logic [95:0] wq_entry_state,
    input wire logic [7:0] inval_state,
    output logic unfilter_off,
    output logic fragment_off,
    output logic cache_readonly_pages,
    output logic cache_writeonly_pages,
    output logic [5:0] upstream_credit_count,
    output logic device_entry_cache_off,
    output logic [4:0] entry_disable_count,
    output logic [5:0] cache0_entry_disable,
    output logic [5:0] cache1_entry_disable,
    output logic ats_no_buffer,
    output logic send_filter_off,
    output logic strict_order_on,
    output logic invalidate_whole_cache,
    output logic requester_hash_select,
    output logic update_interleave_on,
    output logic pretranslated_no_va_filter,
    output logic coarse_filter_on,
    output logic outstanding_filter_on,
    output logic [23:0] wrong_mode_fill,
    output logic [31:0] inval_pulse_width
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0] dbg_a;          // Debug control a
        logic [31:0] dbg_b;          // Debug control b
        logic small_irq;             // Sticky short interrupt flag
        logic [31:0] ctrl0;          // Writable part only
        logic [31:0] ctrl1;
        logic [31:0] ctrl2;
        logic [31:0] ctrl3;
        logic [31:0] bank_sel;
        logic [31:0] bank_dis;
        logic [31:0] rdata;          // Read answer, one cycle only
        iltc_pkg::iltc_state_type fsm;
        logic pend_cmd;              // Completion wait queued
        logic pend_inv;              // Invalidation queued
        logic cmd_done;
        logic inv_done;
        iltc_pkg::iltc_result_type res;
    } iltc_regs_type;

    iltc_regs_type r;                // Registered state
    iltc_regs_type next_r;           // Next state

    // ==========================================================
    // Helpers
    // Masked write keeps read-only and reserved bits untouched
    function automatic logic [31:0] masked_wr(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [31:0] mask);
        masked_wr = (old & ~mask) | (wd & mask);
    endfunction

    // Queue index from the low port bits; limited by built queue count
    function automatic logic [3:0] port_hash(input logic [7:0] id,
                                             input logic [2:0] nbits,
                                             input logic [2:0] vq_code);
        logic [3:0] m;
        logic [2:0] n;
        n = (nbits < vq_code) ? nbits : vq_code;
        m = 4'((5'h01 << n) - 5'h01);
        port_hash = id[3:0] & m;
    endfunction

    // Ctrl0 as software sees it, with hardware fields filled in
    function automatic logic [31:0] ctrl0_view(input logic [31:0] c);
        logic [31:0] v;
        v = c;
        v[iltc_pkg::P_CACHE_CNT +: 2] = CACHE_COUNT;
        v[iltc_pkg::P_ENTRIES +: 4] = ENTRIES_EXP;
        v[iltc_pkg::P_VQ_CNT +: 3] = VQ_CODE;
        ctrl0_view = v;
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic wr_hit;
        logic cw_ready;
        logic inv_ready;
        wr_hit = 1'b0;
        cw_ready = 1'b0;
        inv_ready = 1'b0;
        next_r = r;
        next_r.cmd_done = 1'b0;
        next_r.inv_done = 1'b0;
        next_r.rdata = 32'h0000_0000;

        // Register writes; read-only words take no effect
        if (bus.wr) begin
            case (bus.addr)
                iltc_pkg::OFF_DBG_A: next_r.dbg_a = bus.wdata;
                iltc_pkg::OFF_DBG_B: next_r.dbg_b = bus.wdata;
                iltc_pkg::OFF_CTRL0: begin
                    next_r.ctrl0 = masked_wr(r.ctrl0, bus.wdata, iltc_pkg::WM_CTRL0);
                end
                iltc_pkg::OFF_CTRL1: begin
                    next_r.ctrl1 = masked_wr(r.ctrl1, bus.wdata, iltc_pkg::WM_CTRL1);
                end
                iltc_pkg::OFF_CTRL2: begin
                    next_r.ctrl2 = masked_wr(r.ctrl2, bus.wdata, iltc_pkg::WM_CTRL2);
                end
                iltc_pkg::OFF_CTRL3: next_r.ctrl3 = bus.wdata;
                iltc_pkg::OFF_BANK_SEL: begin
                    next_r.bank_sel = masked_wr(r.bank_sel, bus.wdata,
                                                iltc_pkg::WM_BANK_SEL);
                end
                iltc_pkg::OFF_BANK_DIS: begin
                    next_r.bank_dis = masked_wr(r.bank_dis, bus.wdata,
                                                iltc_pkg::WM_BANK_DIS);
                end
                default: next_r.dbg_a = r.dbg_a;
            endcase
        end

        // Sticky flag: an event in the clearing cycle wins
        wr_hit = bus.wr && (bus.addr == iltc_pkg::OFF_DBG_A)
                 && bus.wdata[iltc_pkg::B_SMALL_IRQ];
        if (small_irq_evt) begin
            next_r.small_irq = 1'b1;
        end else if (wr_hit) begin
            next_r.small_irq = 1'b0;
        end

        // Register reads; unmapped indices answer zero
        if (bus.rd) begin
            case (bus.addr)
                iltc_pkg::OFF_DBG_A: next_r.rdata = r.dbg_a;
                iltc_pkg::OFF_DBG_B: next_r.rdata = r.dbg_b;
                iltc_pkg::OFF_DBG_STAT: next_r.rdata = {31'h0, r.small_irq};
                iltc_pkg::OFF_CTRL0: next_r.rdata = ctrl0_view(r.ctrl0);
                iltc_pkg::OFF_CTRL1: next_r.rdata = r.ctrl1;
                iltc_pkg::OFF_CTRL2: next_r.rdata = r.ctrl2;
                iltc_pkg::OFF_CTRL3: next_r.rdata = r.ctrl3;
                iltc_pkg::OFF_BANK_SEL: next_r.rdata = r.bank_sel;
                iltc_pkg::OFF_BANK_DIS: next_r.rdata = r.bank_dis;
                iltc_pkg::OFF_WQ_A: next_r.rdata = {2'h0, wq_entry_state[29:0]};
                iltc_pkg::OFF_WQ_B: next_r.rdata = {2'h0, wq_entry_state[59:30]};
                iltc_pkg::OFF_WQ_C: next_r.rdata = {2'h0, wq_entry_state[89:60]};
                iltc_pkg::OFF_WQ_D: begin
                    next_r.rdata = {16'h0, inval_state, 2'h0, wq_entry_state[95:90]};
                end
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end

        // Requests are pulses; queue them so none is lost while busy
        if (cmd_wait_req) begin
            next_r.pend_cmd = 1'b1;
        end
        if (inval_req) begin
            next_r.pend_inv = 1'b1;
        end

        // Each wait term can be switched off separately
        cw_ready = (wq_empty || r.dbg_b[iltc_pkg::B_CW_NO_WQ])
                   && (reads_done || r.dbg_b[iltc_pkg::B_CW_NO_RD]);
        inv_ready = (wq_empty || r.dbg_b[iltc_pkg::B_INV_NO_WQ])
                    && (reads_done || r.dbg_b[iltc_pkg::B_INV_NO_RD]);

        // Completion sequencer; completion wait has priority
        case (r.fsm)
            iltc_pkg::st_idle: begin
                if (r.pend_cmd) begin
                    next_r.fsm = iltc_pkg::st_cmd;
                    next_r.pend_cmd = cmd_wait_req;
                end else if (r.pend_inv) begin
                    next_r.fsm = iltc_pkg::st_inv;
                    next_r.pend_inv = inval_req;
                end
            end
            iltc_pkg::st_cmd: begin
                if (cw_ready) begin
                    next_r.cmd_done = 1'b1;
                    next_r.fsm = iltc_pkg::st_idle;
                end
            end
            iltc_pkg::st_inv: begin
                if (inv_ready) begin
                    next_r.inv_done = 1'b1;
                    next_r.fsm = iltc_pkg::st_idle;
                end
            end
            default: next_r.fsm = iltc_pkg::st_idle;
        endcase

        // Lookup steering, one cycle of latency
        next_r.res.valid = lookup.valid;
        next_r.res.func = (lookup.phantom && !r.dbg_b[iltc_pkg::B_PHANTOM_KEEP])
                          ? 3'h0 : lookup.func;
        next_r.res.vq = port_hash(lookup.port_id,
                                  r.ctrl1[iltc_pkg::P_PORT_BITS +: 3], VQ_CODE);
        // Bank choice only matters when two caches exist
        next_r.res.bank = (CACHE_COUNT == 2'h2)
                          && (^(r.bank_sel[7:0] & lookup.va));
        next_r.res.bypass = r.ctrl1[iltc_pkg::B_BYPASS];
        next_r.res.hit = lookup.hit && !r.ctrl1[iltc_pkg::B_BYPASS]
                         && !(lookup.parity_fail
                              && r.ctrl1[iltc_pkg::B_PARITY_MISS]);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            r.dbg_a <= iltc_pkg::RST_DBG;
            r.dbg_b <= iltc_pkg::RST_DBG;
            r.small_irq <= 1'b0;
            r.ctrl0 <= iltc_pkg::RST_CTRL0;
            r.ctrl1 <= iltc_pkg::RST_CTRL1;
            r.ctrl2 <= iltc_pkg::RST_CTRL2;
            r.ctrl3 <= iltc_pkg::RST_CTRL3;
            r.bank_sel <= iltc_pkg::RST_BANK;
            r.bank_dis <= iltc_pkg::RST_BANK;
            r.rdata <= 32'h0000_0000;
            r.fsm <= iltc_pkg::st_idle;
            r.pend_cmd <= 1'b0;
            r.pend_inv <= 1'b0;
            r.cmd_done <= 1'b0;
            r.inv_done <= 1'b0;
            r.res <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs, all slices of registered state
    assign rdata = r.rdata;
    assign cmd_wait_done = r.cmd_done;
    assign inval_done = r.inv_done;
    assign result = r.res;
    assign unfilter_off = r.ctrl0[iltc_pkg::B_UNFILT_OFF];
    assign fragment_off = r.ctrl0[iltc_pkg::B_FRAG_OFF];
    assign cache_readonly_pages = r.ctrl0[iltc_pkg::B_CACHE_RO];
    assign cache_writeonly_pages = r.ctrl0[iltc_pkg::B_CACHE_WO];
    assign upstream_credit_count = r.ctrl0[iltc_pkg::P_CREDIT +: 6];
    assign device_entry_cache_off = r.ctrl1[iltc_pkg::B_DTE_OFF];
    assign entry_disable_count = r.ctrl1[iltc_pkg::P_ENTRY_DIS +: 5];
    assign cache0_entry_disable = r.bank_dis[5:0];
    assign cache1_entry_disable = r.bank_dis[iltc_pkg::P_CACHE1_DIS +: 6];
    assign ats_no_buffer = r.ctrl1[iltc_pkg::B_ATS_NOBUF];
    assign send_filter_off = r.ctrl1[iltc_pkg::B_SND_FILT_OFF];
    assign strict_order_on = r.ctrl1[iltc_pkg::B_ORDER];
    assign invalidate_whole_cache = r.ctrl1[iltc_pkg::B_INV_ALL];
    assign requester_hash_select = r.ctrl1[iltc_pkg::B_REQID_HASH];
    assign update_interleave_on = r.ctrl1[iltc_pkg::B_INTERLEAVE];
    assign pretranslated_no_va_filter = r.ctrl1[iltc_pkg::B_NO_VA_FILT];
    assign coarse_filter_on = r.ctrl1[iltc_pkg::B_COARSE];
    assign outstanding_filter_on = r.dbg_b[iltc_pkg::B_OUTST_FILT];
    assign wrong_mode_fill = r.ctrl2[iltc_pkg::P_WM_FILL +: 24];
    assign inval_pulse_width = r.ctrl3;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence clear_wr_s;
        bus.wr && bus.addr == iltc_pkg::OFF_DBG_A && bus.wdata[0];
    endsequence
    sequence cmd_wait_s;
        r.fsm == iltc_pkg::st_cmd;
    endsequence
    sequence cmd_blocked_s;
        !wq_empty && !r.dbg_b[iltc_pkg::B_CW_NO_WQ];
    endsequence

    flag_set_a: assert property (small_irq_evt |=> r.small_irq [*1])
        else $error("short interrupt flag not set");
    flag_clear_a: assert property (clear_wr_s ##0 !small_irq_evt |=> !r.small_irq)
        else $error("short interrupt flag not cleared");
    phantom_func_a: assert property (lookup.valid && lookup.phantom
                                      && !r.dbg_b[0] |=> result.func == 3'h0)
        else $error("phantom function number kept");
    cmd_wait_a: assert property (cmd_wait_s ##0 cmd_blocked_s |=> !cmd_wait_done)
        else $error("completion wait ended with queue busy");
    cmd_ready_a: assert property (cmd_wait_s ##0 wq_empty && reads_done
                                  |=> cmd_wait_done ##1 !cmd_wait_done)
        else $error("completion wait not one pulse");
    inv_wait_a: assert property (r.fsm == iltc_pkg::st_inv && !reads_done
                                 && !r.dbg_b[iltc_pkg::B_INV_NO_RD] |=> !inval_done)
        else $error("invalidation ended with reads open");
    parity_miss_a: assert property (lookup.hit && lookup.parity_fail
                                    && r.ctrl1[10] |=> !result.hit)
        else $error("parity failure not forced to miss");
    bypass_miss_a: assert property (r.ctrl1[9] && $stable(r.ctrl1)
                                    |=> result.bypass && !result.hit)
        else $error("bypass not applied");
    bank_pick_a: assert property (lookup.valid && CACHE_COUNT == 2'h2
                                  |=> result.bank == $past(^(r.bank_sel[7:0] & lookup.va)))
        else $error("bank choice wrong");
    hw_field_a: assert property (bus.rd && bus.addr == iltc_pkg::OFF_CTRL0
                                 |=> rdata[21:20] == CACHE_COUNT && rdata[30:28] == VQ_CODE)
        else $error("hardware count fields wrong");
    reserved_zero_a: assert property (bus.rd && bus.addr == iltc_pkg::OFF_CTRL2
                                      |=> rdata[3:0] == 4'h0 && rdata[31:28] == 4'h0)
        else $error("reserved bits not zero");
    credit_load_a: assert property (bus.wr && bus.addr == iltc_pkg::OFF_CTRL0
                                    |=> upstream_credit_count == $past(bus.wdata[13:8]))
        else $error("credit field not loaded");

endmodule

/* File: verif/iltc_far_model.sv */
// Far-side model: workqueue drain, read completion and entry status feed.
// Assumes the bench pulses busy_go for one cycle to load queued traffic.
`timescale 1ns/1ps
module iltc_far_model (
    input wire logic clk,
    input wire logic busy_go,
    output logic wq_empty,
    output logic reads_done,
    output logic [95:0] wq_entry_state,
    output logic [7:0] inval_state
);
    // ==========================================================
    // Drain counter, slow on purpose so a wait has to hold
    logic [3:0] drain = 4'h0;
    always_ff @(posedge clk) begin
        if (busy_go) begin
            drain <= 4'hA;
        end else if (drain != 4'h0) begin
            drain <= drain - 4'h1;
        end
    end
    // Reads finish a little before the queue runs empty
    assign wq_empty = (drain == 4'h0);
    assign reads_done = (drain < 4'h2);
    // ==========================================================
    // Entry k shows code k mod 6, so codes 0 to 5 all appear
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            wq_entry_state[3*k +: 3] = 3'(k % 6);
        end
    end
    assign inval_state = 8'hA5;
endmodule

/* File: verif/test_iltc_ctrl.sv */
// Self-checking bench for the level-1 translation cache control block.
// Assumes a 200 MHz core clock and the far-side model beside the design.
`timescale 1ns/1ps
module test_iltc_ctrl;
    // ==========================================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic srst = 1'b1;
    iltc_pkg::iltc_bus_type bus = '0;
    iltc_pkg::iltc_lookup_type lookup = '0;
    iltc_pkg::iltc_result_type result;
    logic small_irq_evt = 1'b0;
    logic cmd_wait_req = 1'b0;
    logic inval_req = 1'b0;
    logic busy_go = 1'b0;
    logic wq_empty, reads_done, cmd_wait_done, inval_done;
    logic [95:0] wq_entry_state;
    logic [7:0] inval_state;
    logic [31:0] rdata, v, want, pulse_width;
    logic [5:0] credits;
    logic [23:0] fill;
    // Control knobs, gathered so one compare covers them all
    wire [3:0] pg;
    wire [9:0] sw;
    wire [4:0] edc;
    wire [5:0] d0, d1;
    int errors = 0;
    int tests_run = 0;
    int n;
    // Row: index, value written, value read back
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} iltc_row_type;
    iltc_row_type rows [10] = '{'{8'h0C, 32'hFFFF_FFFF, 32'h3520_3F2F},
        '{8'h0D, 32'hFFFF_FFFF, 32'h7FFF_DF77}, '{8'h0E, 32'hFFFF_FFFF, 32'h0FFF_FFF0},
        '{8'h0F, 32'h1234_5678, 32'h1234_5678}, '{8'h10, 32'hFFFF_FFFF, 32'h0000_FFFF},
        '{8'h11, 32'hFFFF_FFFF, 32'h0000_3F3F}, '{8'h06, 32'h1234_5670, 32'h1234_5670},
        '{8'h08, 32'hFFFF_FFFF, 32'h0000_0000}, '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000},
        '{8'h07, 32'h0000_0800, 32'h0000_0800}};
    always #2.5 clk = ~clk;
    // ==========================================================
    // Two caches so the bank hash is live
    iltc_ctrl #(.CACHE_COUNT(2'h2), .ENTRIES_EXP(4'h5), .VQ_CODE(3'h3)) iltc_ctrl_inst (
        .clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .small_irq_evt(small_irq_evt),
        .cmd_wait_req(cmd_wait_req), .inval_req(inval_req), .wq_empty(wq_empty),
        .reads_done(reads_done), .cmd_wait_done(cmd_wait_done), .inval_done(inval_done),
        .lookup(lookup), .result(result), .wq_entry_state(wq_entry_state),
        .inval_state(inval_state), .unfilter_off(pg[0]), .fragment_off(pg[1]),
        .cache_readonly_pages(pg[2]), .cache_writeonly_pages(pg[3]),
        .upstream_credit_count(credits), .device_entry_cache_off(sw[0]),
        .entry_disable_count(edc), .cache0_entry_disable(d0), .cache1_entry_disable(d1),
        .ats_no_buffer(sw[1]), .send_filter_off(sw[2]), .strict_order_on(sw[3]),
        .invalidate_whole_cache(sw[4]), .requester_hash_select(sw[5]),
        .update_interleave_on(sw[6]), .pretranslated_no_va_filter(sw[7]),
        .coarse_filter_on(sw[8]), .outstanding_filter_on(sw[9]), .wrong_mode_fill(fill),
        .inval_pulse_width(pulse_width));
    iltc_far_model iltc_far_model_inst (.clk(clk), .busy_go(busy_go), .wq_empty(wq_empty),
        .reads_done(reads_done), .wq_entry_state(wq_entry_state), .inval_state(inval_state));
    // ==========================================================
    // Shared tasks; each bus cycle leaves a gap so no signal is set twice
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic report_and_stop();
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
        // Every writable knob was set to one by the rows above
        chk({1'b0, sw, pg, edc, d0, d1}, 32'h7FFF_FFFF);
        chk({26'h0, credits}, 32'h0000_003F);
        // Status words ignore writes and mirror the queue
        for (int w = 0; w < 4; w++) begin
            wr(8'(8'h20 + w), 32'hFFFF_FFFF);
            rd(8'(8'h20 + w), v);
            want = (w < 3) ? {2'b0, wq_entry_state[30*w +: 30]}
                           : {16'h0, inval_state, 2'b0, wq_entry_state[95:90]};
            chk(v, want);
        end
        // Second reset in mid-run restores defaults
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(8'h0C, v);
        chk(v, 32'h3520_040C);
        chk({26'h0, credits}, 32'h4);
        chk({8'h0, fill}, 32'hFF0C);
        chk(pulse_width, 32'h0005_1615);
        // Only the two page-caching knobs come out of reset set
        chk({1'b0, sw, pg, edc, d0, d1}, 32'h0018_0000);
        // Sticky short-interrupt flag, write-one clear
        small_irq_evt <= 1'b1;
        @(posedge clk);
        small_irq_evt <= 1'b0;
        rd(8'h08, v);
        chk(v, 32'h1);
        wr(8'h06, 32'h1);
        rd(8'h08, v);
        chk(v, 32'h0);
        // Event and clear in one cycle: the event must win
        small_irq_evt <= 1'b1;
        bus <= '{1'b1, 1'b0, 8'h06, 32'h1};
        @(posedge clk);
        small_irq_evt <= 1'b0;
        rd(8'h08, v);
        chk(v, 32'h1);
        // Waits: full wait against busy queue, then both waits skipped
        for (int k = 0; k < 4; k++) begin
            wr(8'h07, k[0] ? (k[1] ? 32'h30 : 32'hC) : 32'h0);
            busy_go <= 1'b1;
            if (k[1]) begin
                inval_req <= 1'b1;
            end else begin
                cmd_wait_req <= 1'b1;
            end
            @(posedge clk);
            {busy_go, inval_req, cmd_wait_req} <= 3'b000;
            n = 0;
            #1;
            while ((k[1] ? inval_done : cmd_wait_done) !== 1'b1 && n < 40) begin
                @(posedge clk);
                #1 n++;
            end
            if (n == 40) begin
                errors++;
                report_and_stop();
            end
            // Two edges to reach the wait state; the model drains after eleven
            chk({31'h0, (k[0] ? n == 2 : n == 11)}, 32'h1);
            @(posedge clk);
        end
        // Lookup steering: phantom, port hash, bank, bypass, parity miss
        // Last pass keeps the function number and turns port hashing off
        wr(8'h10, 32'h0000_0003);
        for (int k = 0; k < 4; k++) begin
            wr(8'h07, {31'h0, k == 3});
            wr(8'h0D, (k == 3) ? 32'h0 : ((k == 1) ? 32'h202 : ((k == 2) ? 32'h402 : 32'h2)));
            lookup <= '{1'b1, 3'h5, 1'b1, 8'hFF, 8'h01, 1'b1, 1'b1};
            @(posedge clk);
            lookup <= '0;
            want = {21'h0, 1'b1, (k == 3) ? 3'h5 : 3'h0, (k == 3) ? 4'h0 : 4'h3, 1'b1,
                    k == 0 || k == 3, k == 1};
            #1 chk({21'h0, result}, want);
            @(posedge clk);
        end
        report_and_stop();
    end
endmodule
